// [bench/csrtc_top_bench.sv]
`timescale 1ns/1ps
module csrtc_top_bench;
	logic       ref_clk_i   = 1'b0;
	logic       sys_rst_i   = 1'b1;
	logic [7:0] addr_i      = 8'h00;
	logic [7:0] wdata_i     = 8'h00;
	logic       wr_i        = 1'b0;
	logic       rd_i        = 1'b0;
	logic       stop_mode_i = 1'b0;
	logic [7:0] rdata_o;
	logic       cpu_clk_en_o;
	logic       bus_clk_en_o;
	logic       cpu_on_pll_o;
	logic       osc_running_o;
	logic       rtc_irq_o;
	int         fails    = 0;
	int         compares = 0;
	int         seed     = 32'hbda92f10;
	int         al [3];
	int         n;
	logic [7:0] v;
	logic [7:0] a;

	always #5 ref_clk_i = ~ref_clk_i;

	csrtc_top #(.SEC_OSC_TICKS(4)) DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.stop_mode_i(stop_mode_i), .rdata_o(rdata_o), .cpu_clk_en_o(cpu_clk_en_o),
		.bus_clk_en_o(bus_clk_en_o), .cpu_on_pll_o(cpu_on_pll_o),
		.osc_running_o(osc_running_o), .rtc_irq_o(rtc_irq_o));

	task automatic complete_run;
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : chk

	task automatic chkn(input string what, input int exp, input int got);
		compares++;
		if (got != exp)
		begin
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
			fails++;
		end
	endtask : chkn

	task automatic bound(input int cnt, input int lim);
		if (cnt >= lim)
		begin
			$display("CHECK FAILED wait expected done seen timeout");
			fails++;
			complete_run();
		end
	endtask : bound

	task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
		@(posedge ref_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= wa;
		wdata_i <= wd;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ra, output logic [7:0] rv);
		@(posedge ref_clk_i);
		rd_i   <= 1'b1;
		addr_i <= ra;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask : rd

	task automatic rdchk(input string what, input logic [7:0] ra, input logic [7:0] exp);
		logic [7:0] rv;
		rd(ra, rv);
		chk(what, exp, rv);
	endtask : rdchk

	task automatic wait_bus(input bit cpu, output int c);
		c = 0;
		do
		begin
			@(negedge ref_clk_i);
			c++;
		end while ((cpu ? cpu_clk_en_o : bus_clk_en_o) !== 1'b1 && c < 4000);
		bound(c, 4000);
	endtask : wait_bus

	task automatic poll_sec(input logic [7:0] s);
		int k;
		k = 0;
		do
		begin
			rd(csrtc_pkg::OFF_TIME_SECONDS, v);
			k++;
		end while (v !== s && k < 20000);
		bound(k, 20000);
	endtask : poll_sec

	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("cpu on loop", 8'h00, {7'h0, cpu_on_pll_o});
		chk("osc running", 8'h01, {7'h0, osc_running_o});
		for (int i = 0; i < 3; i++)
			rdchk("alarm reset", 8'(csrtc_pkg::OFF_ALARM_HOURS + i), 8'h00);
		rdchk("clock control reset", csrtc_pkg::OFF_CLK_CONTROL, 8'h00);
		// Time and alarm both come out of reset at zero, so the alarm flag is already up.
		rdchk("status reset", csrtc_pkg::OFF_RTC_STATUS, 8'h02);
		rdchk("enable reset", csrtc_pkg::OFF_RTC_CONTROL, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			al[i] = $random(seed) & 8'hFF;
			wr(8'(csrtc_pkg::OFF_ALARM_HOURS + i), 8'(al[i]));
		end
		a = 8'(8'h30 + ($random(seed) & 8'h0F));
		wr(a, 8'hA5);
		rdchk("unmapped", a, 8'h00);
		for (int i = 0; i < 3; i++)
			rdchk("alarm", 8'(csrtc_pkg::OFF_ALARM_HOURS + i), 8'(al[i]));
		for (int fs = 0; fs < 4; fs++)
		begin
			wr(csrtc_pkg::OFF_CLK_CONTROL, {1'b1, 2'(fs), 5'h01});
			rd(csrtc_pkg::OFF_CLK_CONTROL, v);
			chk("clock control", {1'b1, 2'(fs), 5'h00}, v);
			wait_bus(1'b0, n);
			wait_bus(1'b0, n);
			wait_bus(1'b0, n);
			chkn("bus period", 2 * int'(csrtc_pkg::PLL_CYC[fs]), n);
		end
		chk("cpu on loop", 8'h01, {7'h0, cpu_on_pll_o});
		wait_bus(1'b1, n);
		wait_bus(1'b1, n);
		chkn("cpu period", int'(csrtc_pkg::PLL_CYC[3]), n);
		wr(csrtc_pkg::OFF_CLK_CONTROL, 8'hF0);
		@(posedge ref_clk_i);
		stop_mode_i <= 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk("osc running", 8'h00, {7'h0, osc_running_o});
		rd(csrtc_pkg::OFF_TIME_SECONDS, a);
		repeat (13000) @(posedge ref_clk_i);
		rdchk("seconds frozen", csrtc_pkg::OFF_TIME_SECONDS, a);
		@(posedge ref_clk_i);
		stop_mode_i <= 1'b0;
		repeat (3) @(negedge ref_clk_i);
		chk("osc running", 8'h01, {7'h0, osc_running_o});
		wr(csrtc_pkg::OFF_CLK_CONTROL, 8'h00);
		n = 0;
		do
		begin
			@(negedge ref_clk_i);
			n++;
		end while (cpu_on_pll_o !== 1'b0 && n < 4000);
		bound(n, 4000);
		wait_bus(1'b1, n);
		wait_bus(1'b1, n);
		chkn("cpu period", int'(csrtc_pkg::OSC_DIV_CYC), n);
		wr(csrtc_pkg::OFF_TIME_HOURS, 8'h17);
		wr(csrtc_pkg::OFF_TIME_MINUTES, 8'h3B);
		wr(csrtc_pkg::OFF_TIME_SECONDS, 8'h3A);
		wr(csrtc_pkg::OFF_ALARM_HOURS, 8'h00);
		wr(csrtc_pkg::OFF_ALARM_MINUTES, 8'h00);
		wr(csrtc_pkg::OFF_RTC_CONTROL, 8'h07);
		wr(csrtc_pkg::OFF_RTC_STATUS, 8'h07);
		rdchk("seconds", csrtc_pkg::OFF_TIME_SECONDS, 8'h3A);
		rdchk("hours", csrtc_pkg::OFF_TIME_HOURS, 8'h17);
		rdchk("minutes", csrtc_pkg::OFF_TIME_MINUTES, 8'h3B);
		poll_sec(8'h00);
		rdchk("hours wrap", csrtc_pkg::OFF_TIME_HOURS, 8'h00);
		rdchk("minutes wrap", csrtc_pkg::OFF_TIME_MINUTES, 8'h00);
		rdchk("status", csrtc_pkg::OFF_RTC_STATUS, 8'h07);
		chk("irq", 8'h01, {7'h0, rtc_irq_o});
		wr(csrtc_pkg::OFF_RTC_STATUS, 8'h07);
		rdchk("status", csrtc_pkg::OFF_RTC_STATUS, 8'h02);
		wr(csrtc_pkg::OFF_ALARM_MINUTES, 8'h05);
		wr(csrtc_pkg::OFF_RTC_STATUS, 8'h02);
		rdchk("status", csrtc_pkg::OFF_RTC_STATUS, 8'h00);
		wr(csrtc_pkg::OFF_RTC_CONTROL, 8'h00);
		poll_sec(8'h01);
		rdchk("status", csrtc_pkg::OFF_RTC_STATUS, 8'h04);
		@(negedge ref_clk_i);
		chk("irq", 8'h00, {7'h0, rtc_irq_o});
		complete_run();
	end
endmodule : csrtc_top_bench

// [bench/csrtc_top_chk.sv]
`timescale 1ns/1ps
module csrtc_top_chk #(
	parameter int SEC_OSC_TICKS = 32768
) (
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic       stop_mode_i,
	input  wire logic [7:0] rdata_o,
	input  wire logic       cpu_clk_en_o,
	input  wire logic       bus_clk_en_o,
	input  wire logic       cpu_on_pll_o,
	input  wire logic       osc_running_o,
	input  wire logic       rtc_irq_o
);
	logic [3:0] ctl_sh;
	logic [2:0] en_sh;
	logic [7:0] alh_sh;
	wire        ctl_wr = wr_i && addr_i == csrtc_pkg::OFF_CLK_CONTROL;
	wire        ctl_rd = rd_i && addr_i == csrtc_pkg::OFF_CLK_CONTROL;
	wire        en_wr  = wr_i && addr_i == csrtc_pkg::OFF_RTC_CONTROL;
	wire        alh_wr = wr_i && addr_i == csrtc_pkg::OFF_ALARM_HOURS;
	wire        alh_rd = rd_i && addr_i == csrtc_pkg::OFF_ALARM_HOURS;

	always_ff @(posedge ref_clk_i)
		ctl_sh <= sys_rst_i ? 4'h0 : ctl_wr ? wdata_i[7:4] : ctl_sh;
	always_ff @(posedge ref_clk_i)
		en_sh <= sys_rst_i ? 3'h0 : en_wr ? wdata_i[2:0] : en_sh;
	always_ff @(posedge ref_clk_i)
		alh_sh <= sys_rst_i ? 8'h00 : alh_wr ? wdata_i : alh_sh;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	reset_out_a: assert property ($fell(sys_rst_i) |-> !cpu_on_pll_o && !cpu_clk_en_o
		&& osc_running_o && !rtc_irq_o) else $error("outputs wrong after reset");
	osc_stop_a: assert property (
		##1 osc_running_o == !($past(stop_mode_i) && $past(ctl_sh[0])))
		else $error("oscillator run state wrong");
	src_rise_a: assert property ($rose(ctl_sh[3]) |-> ##[1:400] cpu_on_pll_o)
		else $error("cpu did not move to loop clock");
	src_fall_a: assert property ($fell(cpu_on_pll_o) |-> !ctl_sh[3])
		else $error("cpu left loop clock while selected");
	bus_gap_a: assert property (bus_clk_en_o |=> !bus_clk_en_o [*8])
		else $error("bus clock pulses too close");
	irq_gate_a: assert property (rtc_irq_o |-> $past(en_sh) != 3'h0)
		else $error("interrupt without enable");
	ctl_read_a: assert property (
		$past(ctl_rd) |-> rdata_o[7:1] == {$past(ctl_sh), 3'h0})
		else $error("clock control read wrong");
	alarm_read_a: assert property ($past(alh_rd) |-> rdata_o == $past(alh_sh))
		else $error("alarm hours read wrong");

	cover property ($rose(cpu_on_pll_o));
	cover property (rtc_irq_o);
	cover property (!osc_running_o);
endmodule : csrtc_top_chk

bind csrtc_top csrtc_top_chk #(.SEC_OSC_TICKS(SEC_OSC_TICKS)) chk (.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.stop_mode_i(stop_mode_i), .rdata_o(rdata_o), .cpu_clk_en_o(cpu_clk_en_o),
	.bus_clk_en_o(bus_clk_en_o), .cpu_on_pll_o(cpu_on_pll_o), .osc_running_o(osc_running_o),
	.rtc_irq_o(rtc_irq_o));

// [core/csrtc_pkg.sv]
package csrtc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] OFF_ALARM_HOURS   = 8'h0C;
	localparam logic [7:0] OFF_ALARM_MINUTES = 8'h0D;
	localparam logic [7:0] OFF_ALARM_SECONDS = 8'h0E;
	localparam logic [7:0] OFF_TIME_HOURS    = 8'h0F;
	localparam logic [7:0] OFF_TIME_MINUTES  = 8'h10;
	localparam logic [7:0] OFF_TIME_SECONDS  = 8'h11;
	localparam logic [7:0] OFF_RTC_STATUS    = 8'h1C;
	localparam logic [7:0] OFF_RTC_CONTROL   = 8'h1D;
	localparam logic [7:0] OFF_CLK_CONTROL   = 8'h24;

	localparam int POS_CPU_SRC  = 7;
	localparam int POS_FS_HIGH  = 6;
	localparam int POS_FS_LOW   = 5;
	localparam int POS_OSC_OFF  = 4;
	localparam int POS_LOCKED   = 0;
	localparam int POS_DAY      = 0;
	localparam int POS_ALARM    = 1;
	localparam int POS_SECOND   = 2;

	localparam logic [7:0] RST_ALARM     = 8'h00;
	localparam logic [7:0] RST_TIME      = 8'h00;
	localparam logic [1:0] RST_FREQ_SEL  = 2'h0;
	localparam logic       RST_CPU_SRC   = 1'b0;
	localparam logic       RST_OSC_OFF   = 1'b0;
	localparam logic       RST_LOCKED    = 1'b0;
	localparam logic [2:0] RST_FLAGS     = 3'h0;
	localparam logic [2:0] RST_IRQ_EN    = 3'h0;

	localparam int CLK_HZ        = 100_000_000;
	localparam int OSC_HZ        = 32768;
	localparam int REF_HZ        = 1000;
	localparam int SEC_OSC_TICKS = 32768;
	localparam logic [11:0] OSC_DIV_CYC   = 12'(CLK_HZ / OSC_HZ);
	localparam logic [4:0]  REF_LAST_TICK = 5'((OSC_HZ / REF_HZ) - 1);

	localparam int PLL_HZ [4] = '{328000, 2622000, 656000, 5244000};
	localparam int VCO_HZ [4] = '{288000, 2604000, 576000, 5208000};
	localparam logic [8:0] PLL_CYC [4] = '{9'(CLK_HZ / PLL_HZ[0]), 9'(CLK_HZ / PLL_HZ[1]),
		9'(CLK_HZ / PLL_HZ[2]), 9'(CLK_HZ / PLL_HZ[3])};
	localparam logic [8:0] VCO_CYC [4] = '{9'(CLK_HZ / VCO_HZ[0]), 9'(CLK_HZ / VCO_HZ[1]),
		9'(CLK_HZ / VCO_HZ[2]), 9'(CLK_HZ / VCO_HZ[3])};
	localparam logic [13:0] VCO_PER_REF [4] = '{
		14'((VCO_HZ[0] / OSC_HZ) * (OSC_HZ / REF_HZ) + (VCO_HZ[0] % OSC_HZ) * 32 / OSC_HZ),
		14'((VCO_HZ[1] / OSC_HZ) * (OSC_HZ / REF_HZ) + (VCO_HZ[1] % OSC_HZ) * 32 / OSC_HZ),
		14'((VCO_HZ[2] / OSC_HZ) * (OSC_HZ / REF_HZ) + (VCO_HZ[2] % OSC_HZ) * 32 / OSC_HZ),
		14'((VCO_HZ[3] / OSC_HZ) * (OSC_HZ / REF_HZ) + (VCO_HZ[3] % OSC_HZ) * 32 / OSC_HZ)};
	localparam logic [13:0] LOCK_TOL     = 14'h0004;
	localparam logic [1:0]  LOCK_PERIODS = 2'h2;

	localparam logic [7:0] SEC_LAST  = 8'h3B;
	localparam logic [7:0] MIN_LAST  = 8'h3B;
	localparam logic [7:0] HOUR_LAST = 8'h17;

	typedef enum logic [1:0] {
		src_osc    = 2'b00,
		src_to_pll = 2'b01,
		src_pll    = 2'b11,
		src_to_osc = 2'b10
	} csrtc_src_state_t;

endpackage : csrtc_pkg

// [core/csrtc_pll.sv]
`timescale 1ns/1ps
module csrtc_pll (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic osc_tick_i,
	csrtc_pll_if.pll  link
);
	logic [8:0]  out_cnt;
	logic [8:0]  vco_cnt;
	logic        vco_tick;
	logic [13:0] meas;
	logic [4:0]  ref_cnt;
	logic [1:0]  good;
	logic [1:0]  last_sel;
	logic        pll_tick;
	logic        locked;

	wire logic        out_wrap = (out_cnt >= csrtc_pkg::PLL_CYC[link.freq_sel] - 9'h001);
	wire logic        vco_wrap = (vco_cnt >= csrtc_pkg::VCO_CYC[link.freq_sel] - 9'h001);
	wire logic        ref_edge = osc_tick_i && (ref_cnt == csrtc_pkg::REF_LAST_TICK);
	wire logic [13:0] nominal  = csrtc_pkg::VCO_PER_REF[link.freq_sel];
	wire logic        in_tol   = (meas + csrtc_pkg::LOCK_TOL >= nominal)
		&& (meas <= nominal + csrtc_pkg::LOCK_TOL);

	assign link.pll_tick = pll_tick;
	assign link.locked   = locked;

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			out_cnt  <= 9'h000;
			vco_cnt  <= 9'h000;
			pll_tick <= 1'b0;
			vco_tick <= 1'b0;
		end
		else
		begin
			out_cnt  <= out_wrap ? 9'h000 : out_cnt + 9'h001;
			pll_tick <= out_wrap;
			vco_cnt  <= vco_wrap ? 9'h000 : vco_cnt + 9'h001;
			vco_tick <= vco_wrap;
		end
	end

	// The indicator only moves on a reference edge, so it lags a frequency change.
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			meas     <= 14'h0000;
			ref_cnt  <= 5'h00;
			good     <= 2'h0;
			last_sel <= csrtc_pkg::RST_FREQ_SEL;
			locked   <= csrtc_pkg::RST_LOCKED;
		end
		else
		begin
			last_sel <= link.freq_sel;
			if (osc_tick_i)
				ref_cnt <= ref_cnt + 5'h01;
			if (ref_edge)
				meas <= {13'h0000, vco_tick};
			else if (vco_tick)
				meas <= meas + 14'h0001;
			if (last_sel != link.freq_sel)
				good <= 2'h0;
			else if (ref_edge)
			begin
				good   <= !in_tol ? 2'h0 : (good == csrtc_pkg::LOCK_PERIODS) ? good : good + 2'h1;
				locked <= in_tol && (good >= csrtc_pkg::LOCK_PERIODS - 2'h1);
			end
		end
	end
endmodule : csrtc_pll

// [core/csrtc_pll_if.sv]
`timescale 1ns/1ps
interface csrtc_pll_if;
	logic [1:0] freq_sel;
	logic       pll_tick;
	logic       locked;

	modport ctl (output freq_sel, input pll_tick, input locked);
	modport pll (input freq_sel, output pll_tick, output locked);
endinterface : csrtc_pll_if

// [core/csrtc_top.sv]
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - Reset runs CPU from 32 kHz clock.
// - Source select bit picks PLL or 32 kHz.
// - Frequency select sets PLL output; bus half.
// - Lock indicator is read-only stability status.
// - Reset clears source and frequency select.
// - Oscillator-stop bit disables oscillator in Stop.
// - Same bit chooses continuous or halted clock.
// - Comparator uses 1 kHz reference from crystal.
// - Divide-by-N gives four VCO frequencies.
// - Hours, minutes, seconds counters from oscillator.
// - Hours/minutes writes held until seconds write.
// - Seconds read snapshots hours and minutes.
// - Three alarm registers, reset to zero.
// - Alarm flag set on alarm hours/minutes equal time.
// - Day flag on hours wrapping 23 to 0.
// - Second flag each second; enables gate requests.
// - Flags set regardless of enable bits.
// - Alarm flag holds while match persists.
module csrtc_top #(
	parameter int SEC_OSC_TICKS = csrtc_pkg::SEC_OSC_TICKS
) (
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic       stop_mode_i,
	output logic      [7:0] rdata_o,
	output logic            cpu_clk_en_o,
	output logic            bus_clk_en_o,
	output logic            cpu_on_pll_o,
	output logic            osc_running_o,
	output logic            rtc_irq_o
);
	csrtc_pll_if pll_link ();

	logic                         cpu_clock_source_select;
	logic [1:0]                   freq_sel;
	logic                         osc_off_in_stop;
	logic [7:0]                   alarm_hours;
	logic [7:0]                   alarm_minutes;
	logic [7:0]                   alarm_seconds;
	logic [7:0]                   hold_hours;
	logic [7:0]                   hold_minutes;
	logic [7:0]                   count_hours;
	logic [7:0]                   count_minutes;
	logic [7:0]                   count_seconds;
	logic [2:0]                   flags;
	logic [2:0]                   irq_en;
	logic [11:0]                  osc_cnt;
	logic                         osc_tick;
	logic [15:0]                  sec_cnt;
	logic                         sec_tick;
	logic                         bus_phase;
	csrtc_pkg::csrtc_src_state_t  src_state;
	csrtc_pkg::csrtc_src_state_t  next_src_state;
	logic                         next_cpu_pulse;

	csrtc_pll u_pll (
		.ref_clk_i  (ref_clk_i),
		.sys_rst_i  (sys_rst_i),
		.osc_tick_i (osc_tick),
		.link       (pll_link.pll)
	);

	assign pll_link.freq_sel = freq_sel;

	wire logic freq_select_high = freq_sel[1];
	wire logic freq_select_low  = freq_sel[0];
	wire logic loop_locked_indicator = pll_link.locked;
	wire logic pll_tick = pll_link.pll_tick;

	wire logic hit_alarm_hours   = (addr_i == csrtc_pkg::OFF_ALARM_HOURS);
	wire logic hit_alarm_minutes = (addr_i == csrtc_pkg::OFF_ALARM_MINUTES);
	wire logic hit_alarm_seconds = (addr_i == csrtc_pkg::OFF_ALARM_SECONDS);
	wire logic hit_time_hours    = (addr_i == csrtc_pkg::OFF_TIME_HOURS);
	wire logic hit_time_minutes  = (addr_i == csrtc_pkg::OFF_TIME_MINUTES);
	wire logic hit_time_seconds  = (addr_i == csrtc_pkg::OFF_TIME_SECONDS);
	wire logic hit_status        = (addr_i == csrtc_pkg::OFF_RTC_STATUS);
	wire logic hit_control       = (addr_i == csrtc_pkg::OFF_RTC_CONTROL);
	wire logic hit_clk_control   = (addr_i == csrtc_pkg::OFF_CLK_CONTROL);

	wire logic wr_seconds = wr_i && hit_time_seconds;
	wire logic rd_seconds = rd_i && hit_time_seconds;

	wire logic [7:0] clk_control_view = {cpu_clock_source_select, freq_select_high,
		freq_select_low, osc_off_in_stop, 3'h0, loop_locked_indicator};

	wire logic [7:0] read_value =
		hit_alarm_hours   ? alarm_hours :
		hit_alarm_minutes ? alarm_minutes :
		hit_alarm_seconds ? alarm_seconds :
		hit_time_hours    ? hold_hours :
		hit_time_minutes  ? hold_minutes :
		hit_time_seconds  ? count_seconds :
		hit_status        ? {5'h00, flags} :
		hit_control       ? {5'h00, irq_en} :
		hit_clk_control   ? clk_control_view :
		8'h00;

	// Stop mode comes from the CPU core on this same clock, so it is used directly.
	wire logic osc_enabled = !(stop_mode_i && osc_off_in_stop);
	wire logic osc_wrap    = (osc_cnt >= csrtc_pkg::OSC_DIV_CYC - 12'h001);
	wire logic sec_wrap    = (sec_cnt >= 16'(SEC_OSC_TICKS - 1));

	wire logic sec_last  = (count_seconds >= csrtc_pkg::SEC_LAST);
	wire logic min_last  = (count_minutes >= csrtc_pkg::MIN_LAST);
	wire logic hour_last = (count_hours >= csrtc_pkg::HOUR_LAST);
	wire logic day_event = sec_tick && sec_last && min_last && hour_last;

	// Only hours and minutes take part in the match, so the flag is a level for a minute.
	wire logic alarm_match = (count_hours == alarm_hours)
		&& (count_minutes == alarm_minutes);

	wire logic [2:0] events;
	assign events[csrtc_pkg::POS_DAY]    = day_event;
	assign events[csrtc_pkg::POS_ALARM]  = alarm_match;
	assign events[csrtc_pkg::POS_SECOND] = sec_tick;

	wire logic [2:0] clear_mask = (wr_i && hit_status) ? wdata_i[2:0] : 3'h0;
	// Set wins over the write-one clear when both land in one cycle.
	wire logic [2:0] next_flags = (flags & ~clear_mask) | events;

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			cpu_clock_source_select <= csrtc_pkg::RST_CPU_SRC;
			freq_sel                <= csrtc_pkg::RST_FREQ_SEL;
			osc_off_in_stop         <= csrtc_pkg::RST_OSC_OFF;
			irq_en                  <= csrtc_pkg::RST_IRQ_EN;
		end
		else if (wr_i && hit_clk_control)
		begin
			cpu_clock_source_select <= wdata_i[csrtc_pkg::POS_CPU_SRC];
			freq_sel <= {wdata_i[csrtc_pkg::POS_FS_HIGH], wdata_i[csrtc_pkg::POS_FS_LOW]};
			osc_off_in_stop         <= wdata_i[csrtc_pkg::POS_OSC_OFF];
		end
		else if (wr_i && hit_control)
			irq_en <= wdata_i[2:0];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			alarm_hours   <= csrtc_pkg::RST_ALARM;
			alarm_minutes <= csrtc_pkg::RST_ALARM;
			alarm_seconds <= csrtc_pkg::RST_ALARM;
		end
		else if (wr_i && hit_alarm_hours)
			alarm_hours <= wdata_i;
		else if (wr_i && hit_alarm_minutes)
			alarm_minutes <= wdata_i;
		else if (wr_i && hit_alarm_seconds)
			alarm_seconds <= wdata_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			osc_cnt       <= 12'h000;
			osc_tick      <= 1'b0;
			osc_running_o <= 1'b1;
		end
		else
		begin
			osc_running_o <= osc_enabled;
			osc_tick      <= osc_enabled && osc_wrap;
			if (osc_enabled)
				osc_cnt <= osc_wrap ? 12'h000 : osc_cnt + 12'h001;
		end
	end

	// A seconds write restarts the prescaler so the new second lasts a full second.
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || wr_seconds)
		begin
			sec_cnt  <= 16'h0000;
			sec_tick <= 1'b0;
		end
		else
		begin
			sec_tick <= osc_tick && sec_wrap;
			if (osc_tick)
				sec_cnt <= sec_wrap ? 16'h0000 : sec_cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			count_seconds <= csrtc_pkg::RST_TIME;
			count_minutes <= csrtc_pkg::RST_TIME;
			count_hours   <= csrtc_pkg::RST_TIME;
		end
		else if (wr_seconds)
		begin
			count_seconds <= wdata_i;
			count_minutes <= hold_minutes;
			count_hours   <= hold_hours;
		end
		else if (sec_tick)
		begin
			count_seconds <= sec_last ? 8'h00 : count_seconds + 8'h01;
			if (sec_last)
				count_minutes <= min_last ? 8'h00 : count_minutes + 8'h01;
			if (sec_last && min_last)
				count_hours <= hour_last ? 8'h00 : count_hours + 8'h01;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			hold_hours   <= csrtc_pkg::RST_TIME;
			hold_minutes <= csrtc_pkg::RST_TIME;
		end
		else if (rd_seconds)
		begin
			hold_hours   <= count_hours;
			hold_minutes <= count_minutes;
		end
		else if (wr_i && hit_time_hours)
			hold_hours <= wdata_i;
		else if (wr_i && hit_time_minutes)
			hold_minutes <= wdata_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			flags     <= csrtc_pkg::RST_FLAGS;
			rtc_irq_o <= 1'b0;
			rdata_o   <= 8'h00;
		end
		else
		begin
			flags     <= next_flags;
			rtc_irq_o <= |(flags & irq_en);
			rdata_o   <= rd_i ? read_value : 8'h00;
		end
	end

	// A changeover drops the old source and passes the first pulse of the new one straight through,
	// so the first period after it can be truncated; no idle gap is added.
	always_comb
	begin
		next_src_state = src_state;
		next_cpu_pulse = 1'b0;
		case (src_state)
			csrtc_pkg::src_osc:
			begin
				next_cpu_pulse = osc_tick;
				if (cpu_clock_source_select)
					next_src_state = csrtc_pkg::src_to_pll;
			end
			csrtc_pkg::src_to_pll:
			begin
				next_cpu_pulse = pll_tick;
				if (pll_tick)
					next_src_state = csrtc_pkg::src_pll;
			end
			csrtc_pkg::src_pll:
			begin
				next_cpu_pulse = pll_tick;
				if (!cpu_clock_source_select)
					next_src_state = csrtc_pkg::src_to_osc;
			end
			csrtc_pkg::src_to_osc:
			begin
				next_cpu_pulse = osc_tick;
				if (osc_tick)
					next_src_state = csrtc_pkg::src_osc;
			end
			default:
				next_src_state = csrtc_pkg::src_osc;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			src_state    <= csrtc_pkg::src_osc;
			cpu_clk_en_o <= 1'b0;
			cpu_on_pll_o <= 1'b0;
		end
		else
		begin
			src_state    <= next_src_state;
			cpu_clk_en_o <= next_cpu_pulse;
			cpu_on_pll_o <= (next_src_state == csrtc_pkg::src_pll)
				|| (next_src_state == csrtc_pkg::src_to_osc);
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			bus_phase    <= 1'b0;
			bus_clk_en_o <= 1'b0;
		end
		else
		begin
			if (pll_tick)
				bus_phase <= !bus_phase;
			bus_clk_en_o <= pll_tick && bus_phase;
		end
	end
endmodule : csrtc_top
